// ### pkg/wdt_pkg.sv
// constants, field positions and state types of the watchdog block
// assumes one 200 MHz system clock and a synchronous active-high reset
package wdt_pkg;

  // ****************************************
  // io ports of the index/data pair
  // ****************************************
  localparam logic [15:0] WDT_PORT_INDEX = 16'h0022; // [RULE_12]
  localparam logic [15:0] WDT_PORT_DATA  = 16'h0023; // [RULE_12]

  // ****************************************
  // register indexes
  // ****************************************
  localparam logic [7:0] WDT_IDX_CTRL = 8'h37;
  localparam logic [7:0] WDT_IDX_SEL  = 8'h38;
  localparam logic [7:0] WDT_IDX_CNTL = 8'h39;
  localparam logic [7:0] WDT_IDX_CNTM = 8'h3a;
  localparam logic [7:0] WDT_IDX_CNTH = 8'h3b;
  localparam logic [7:0] WDT_IDX_MISC = 8'h3c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int WDT_CTRL_LATCH_BIT  = 7;
  localparam int WDT_CTRL_ENABLE_BIT = 6;
  localparam int WDT_MISC_STATUS_BIT = 7;
  localparam int WDT_SEL_LSB         = 4;
  localparam int WDT_CNT_W           = 24;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  WDT_RST_BYTE  = 8'h00;
  localparam logic [23:0] WDT_RST_COUNT = 24'h000000;

  // ****************************************
  // count source
  // ****************************************
  localparam int  WDT_CLK_HZ     = 200000000;
  localparam int  WDT_SRC_HZ     = 32768;
  localparam real WDT_STEP_US    = 30.5;

  // ****************************************
  // timeout selector codes
  // ****************************************
  localparam logic [3:0] WDT_SEL_NMI = 4'hc;
  localparam logic [3:0] WDT_SEL_RST = 4'hd;

  typedef struct packed {
    logic [7:0]  index;
    logic [7:0]  ctrl;
    logic [7:0]  sel;
    logic [23:0] term;
    logic [6:0]  misc;
    logic        status;
    logic [23:0] count;
    logic [23:0] snap;
    logic        done;
    logic        fire;
    logic [7:0]  rdata;
  } wdt_top_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic tick;
  } wdt_sync_st_t;

  typedef struct packed {
    logic [15:0] irq;
    logic        nmi;
    logic        rst;
  } wdt_out_st_t;

endpackage : wdt_pkg

// ### pkg/wdt_link_if.sv
// carrier between the watchdog core and its helper modules
// assumes all members run on the system clock
`timescale 1ns/10ps
interface wdt_link_if;
  logic       tick;
  logic       fire;
  logic [3:0] sel;

  modport sync_mp (output tick);
  modport core_mp (input tick, output fire, output sel);
  modport dec_mp  (input fire, input sel);
endinterface : wdt_link_if

// ### logic/wdt_sync.sv
// three-flop synchroniser turning the 32.768 kHz pin into a tick
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/10ps
module wdt_sync
  import wdt_pkg::*;
(
  input  wire logic    sys_clk_i,
  input  wire logic    rst_i,
  input  wire logic    src_clk_i,
  wdt_link_if.sync_mp  link
);

  wdt_sync_st_t st_reg;
  wdt_sync_st_t st_next;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next      = st_reg;
    st_next.s1   = src_clk_i;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.tick = 1'b0;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
      st_next.tick = st_reg.s3 & ~st_reg.lvl; // [RULE_01]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.tick = st_reg.tick;

endmodule : wdt_sync

// ### logic/wdt_out_dec.sv
// decodes the timeout selector into one output pulse
// assumes fire is a one-cycle pulse from the core
`timescale 1ns/10ps
module wdt_out_dec
  import wdt_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  wdt_link_if.dec_mp       link,
  output logic      [15:0] irq_o,
  output logic             nmi_o,
  output logic             sys_reset_o
);

  wdt_out_st_t st_reg;
  wdt_out_st_t st_next;

  // ****************************************
  // selector decode
  // ****************************************
  always_comb begin
    st_next = '0;
    if (link.fire) begin // [RULE_08]
      unique case (link.sel) // [RULE_09]
        4'h1: st_next.irq[3] = 1'b1;
        4'h2: st_next.irq[4] = 1'b1;
        4'h3: st_next.irq[5] = 1'b1;
        4'h4: st_next.irq[6] = 1'b1;
        4'h5: st_next.irq[7] = 1'b1;
        4'h6: st_next.irq[9] = 1'b1;
        4'h7: st_next.irq[10] = 1'b1;
        4'h8: st_next.irq[11] = 1'b1;
        4'h9: st_next.irq[12] = 1'b1;
        4'ha: st_next.irq[14] = 1'b1;
        4'hb: st_next.irq[15] = 1'b1;
        WDT_SEL_NMI: st_next.nmi = 1'b1;
        WDT_SEL_RST: st_next.rst = 1'b1;
        default: st_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq_o       = st_reg.irq;
  assign nmi_o       = st_reg.nmi;
  assign sys_reset_o = st_reg.rst;

endmodule : wdt_out_dec

// ### logic/wdt_top.sv
// watchdog timeout counter behind the index/data configuration ports
// assumes a host issuing one-cycle io strobes on sys_clk_i
`timescale 1ns/10ps

// What this block does
// [RULE_01] count with 24 bits, one step per 32.768 kHz source period
// [RULE_02] control bit 6 runs the watchdog when set, stops it when clear
// [RULE_03] with control bit 7 clear, count bytes read back the terminal count
// [RULE_04] bit 7 rising snapshots the running count; reads return it
// [RULE_05] status bit 7 of the misc register shows a timeout happened
// [RULE_06] terminal count bytes: 3bh high, 3ah middle, 39h low
// [RULE_07] enabled counter counts up from zero toward the terminal count
// [RULE_08] reaching the terminal count drives the output picked by select bits 7:4
// [RULE_09] codes 1 to 11 pick irq lines, 12 nmi, 13 reset, rest reserved
// [RULE_10] writing enable to zero clears the running counter
// [RULE_11] host disables before loading a new terminal count, then enables
// [RULE_12] index written at port 22h, data moved at port 23h
// [RULE_13] output and status fire once, on first equality while enabled
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        src_clk_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  output logic      [15:0] irq_o,
  output logic             nmi_o,
  output logic             sys_reset_o
);

  // ****************************************
  // state and helpers
  // ****************************************
  wdt_top_st_t st_reg;
  wdt_top_st_t st_next;

  wdt_link_if link ();

  // ****************************************
  // port strobes
  // ****************************************
  logic        wr_index;
  logic        wr_data;
  logic        rd_index;
  logic        rd_data;
  logic        wr_ctrl;
  logic        wr_sel;
  logic        wr_cntl;
  logic        wr_cntm;
  logic        wr_cnth;
  logic        wr_misc;

  // ****************************************
  // control and counter helpers
  // ****************************************
  logic        enabled;
  logic        latch_mode;
  logic        ena_clr;
  logic        ena_rise;
  logic        latch_rise;
  logic        hit;
  logic        tick_step;
  logic [23:0] count_inc;
  logic [23:0] shown;
  logic [7:0]  data_rd;

  // ****************************************
  // count source tick
  // ****************************************
  wdt_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .src_clk_i (src_clk_i),
    .link      (link.sync_mp)
  );

  // ****************************************
  // timeout output decode
  // ****************************************
  wdt_out_dec u_dec (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .link        (link.dec_mp),
    .irq_o       (irq_o),
    .nmi_o       (nmi_o),
    .sys_reset_o (sys_reset_o)
  );

  // ****************************************
  // index port decode
  // ****************************************
  assign wr_index = io_wr_i & (io_addr_i == WDT_PORT_INDEX); // [RULE_12]
  assign rd_index = io_rd_i & (io_addr_i == WDT_PORT_INDEX);

  // ****************************************
  // data port decode
  // ****************************************
  assign wr_data  = io_wr_i & (io_addr_i == WDT_PORT_DATA);  // [RULE_12]
  assign rd_data  = io_rd_i & (io_addr_i == WDT_PORT_DATA);

  // ****************************************
  // register write strobes
  // ****************************************
  assign wr_ctrl = wr_data & (st_reg.index == WDT_IDX_CTRL);
  assign wr_sel  = wr_data & (st_reg.index == WDT_IDX_SEL);
  assign wr_cntl = wr_data & (st_reg.index == WDT_IDX_CNTL); // [RULE_06]
  assign wr_cntm = wr_data & (st_reg.index == WDT_IDX_CNTM); // [RULE_06]
  assign wr_cnth = wr_data & (st_reg.index == WDT_IDX_CNTH); // [RULE_06]
  assign wr_misc = wr_data & (st_reg.index == WDT_IDX_MISC);

  // ****************************************
  // control bit events
  // ****************************************
  assign enabled    = st_reg.ctrl[WDT_CTRL_ENABLE_BIT];
  assign latch_mode = st_reg.ctrl[WDT_CTRL_LATCH_BIT];
  assign ena_clr    = wr_ctrl & ~io_wdata_i[WDT_CTRL_ENABLE_BIT]; // [RULE_10]
  assign ena_rise   = wr_ctrl & io_wdata_i[WDT_CTRL_ENABLE_BIT] & ~enabled;
  assign latch_rise = wr_ctrl & io_wdata_i[WDT_CTRL_LATCH_BIT] & ~latch_mode; // [RULE_04]

  // ****************************************
  // counter read source
  // ****************************************
  always_comb begin
    if (latch_mode) begin
      shown = st_reg.snap; // [RULE_04]
    end else begin
      shown = st_reg.term; // [RULE_03]
    end
  end

  // ****************************************
  // data port read mux
  // ****************************************
  always_comb begin
    data_rd = 8'h00;
    unique case (st_reg.index)
      WDT_IDX_CTRL: begin
        data_rd = st_reg.ctrl;
      end
      WDT_IDX_SEL: begin
        data_rd = st_reg.sel;
      end
      WDT_IDX_CNTL: begin
        data_rd = shown[7:0]; // [RULE_06]
      end
      WDT_IDX_CNTM: begin
        data_rd = shown[15:8]; // [RULE_06]
      end
      WDT_IDX_CNTH: begin
        data_rd = shown[23:16]; // [RULE_06]
      end
      WDT_IDX_MISC: begin
        data_rd = {st_reg.status, st_reg.misc}; // [RULE_05]
      end
      default: begin
        data_rd = 8'h00;
      end
    endcase
  end

  // ****************************************
  // terminal match
  // ****************************************
  assign hit = enabled & (st_reg.count == st_reg.term) & ~st_reg.done; // [RULE_13]

  // ****************************************
  // count step
  // ****************************************
  assign tick_step = enabled & link.tick & (st_reg.count != st_reg.term); // [RULE_07]
  assign count_inc = st_reg.count + 24'h000001;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;

    // ****************************************
    // index port
    // ****************************************
    if (wr_index) begin
      st_next.index = io_wdata_i; // [RULE_12]
    end

    // ****************************************
    // running counter
    // ****************************************
    if (!enabled || ena_clr) begin
      st_next.count = WDT_RST_COUNT; // [RULE_02]
    end else if (tick_step) begin
      st_next.count = count_inc; // [RULE_07]
    end

    // ****************************************
    // fired-once flag
    // ****************************************
    if (!enabled || ena_clr) begin
      st_next.done = 1'b0;
    end else if (hit) begin
      st_next.done = 1'b1; // [RULE_13]
    end

    // ****************************************
    // fire pulse
    // ****************************************
    st_next.fire = hit; // [RULE_08]

    // ****************************************
    // status flag, set wins
    // ****************************************
    if (hit) begin
      st_next.status = 1'b1; // [RULE_05]
    end else if (ena_rise) begin
      st_next.status = 1'b0;
    end

    // ****************************************
    // control register
    // ****************************************
    if (wr_ctrl) begin
      st_next.ctrl = io_wdata_i;
    end

    // ****************************************
    // snapshot
    // ****************************************
    if (latch_rise) begin
      st_next.snap = st_reg.count; // [RULE_04]
    end

    // ****************************************
    // select and terminal count
    // ****************************************
    if (wr_sel) begin
      st_next.sel = io_wdata_i; // [RULE_08]
    end
    if (wr_cntl) begin
      st_next.term[7:0] = io_wdata_i; // [RULE_06]
    end
    if (wr_cntm) begin
      st_next.term[15:8] = io_wdata_i; // [RULE_06]
    end
    if (wr_cnth) begin
      st_next.term[23:16] = io_wdata_i; // [RULE_06]
    end

    // ****************************************
    // misc storage
    // ****************************************
    if (wr_misc) begin
      st_next.misc = io_wdata_i[6:0];
    end

    // ****************************************
    // read answer
    // ****************************************
    if (rd_index) begin
      st_next.rdata = st_reg.index;
    end else if (rd_data) begin
      st_next.rdata = data_rd;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg.index  <= WDT_RST_BYTE;
      st_reg.ctrl   <= WDT_RST_BYTE;
      st_reg.sel    <= WDT_RST_BYTE;
      st_reg.term   <= WDT_RST_COUNT;
      st_reg.misc   <= 7'h00;
      st_reg.status <= 1'b0;
      st_reg.count  <= WDT_RST_COUNT;
      st_reg.snap   <= WDT_RST_COUNT;
      st_reg.done   <= 1'b0;
      st_reg.fire   <= 1'b0;
      st_reg.rdata  <= WDT_RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // links to helpers
  // ****************************************
  assign link.fire  = st_reg.fire;
  assign link.sel   = st_reg.sel[WDT_SEL_LSB +: 4]; // [RULE_08]

  // ****************************************
  // top outputs
  // ****************************************
  assign io_rdata_o = st_reg.rdata;

endmodule : wdt_top

// ### dv/wdt_asserts.sv
// assertions on the watchdog top ports
// assumes it is bound onto wdt_top
`timescale 1ns/10ps
module wdt_asserts
  import wdt_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        src_clk_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [7:0]  io_wdata_i,
  input wire logic [7:0]  io_rdata_o,
  input wire logic [15:0] irq_o,
  input wire logic        nmi_o,
  input wire logic        sys_reset_o
);
  // ****************
  // shadow of index, control and terminal
  // ****************
  logic [7:0]  idx_reg;
  logic [7:0]  ctl_reg;
  logic [23:0] trm_reg;
  logic        dwr;
  logic        drd;
  logic        out;
  logic        en;
  assign dwr = io_wr_i && io_addr_i == WDT_PORT_DATA;
  assign drd = io_rd_i && io_addr_i == WDT_PORT_DATA;
  assign out = nmi_o || sys_reset_o || irq_o != 16'h0000;
  assign en  = ctl_reg[WDT_CTRL_ENABLE_BIT];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      idx_reg <= 8'h00;
      ctl_reg <= 8'h00;
      trm_reg <= 24'h000000;
    end else begin
      if (io_wr_i && io_addr_i == WDT_PORT_INDEX) idx_reg <= io_wdata_i;
      if (dwr && idx_reg == WDT_IDX_CTRL) ctl_reg <= io_wdata_i;
      if (dwr && idx_reg == WDT_IDX_CNTL) trm_reg[7:0] <= io_wdata_i;
      if (dwr && idx_reg == WDT_IDX_CNTM) trm_reg[15:8] <= io_wdata_i;
      if (dwr && idx_reg == WDT_IDX_CNTH) trm_reg[23:16] <= io_wdata_i;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_out_onehot: assert property ($onehot0({irq_o, nmi_o, sys_reset_o}))
    else $error("several timeout outputs at once");
  chk_irq_unused: assert property ((irq_o & 16'h2107) == 16'h0000)
    else $error("unused irq line driven");
  chk_nmi_single: assert property (nmi_o |=> !nmi_o)
    else $error("nmi longer than one cycle");
  chk_rst_single: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset request longer than one cycle");
  chk_irq_single: assert property (irq_o != 16'h0000 |=> irq_o == 16'h0000)
    else $error("irq longer than one cycle");
  chk_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without a read");
  chk_term_low: assert property (drd && idx_reg == WDT_IDX_CNTL && !ctl_reg[7]
    |=> io_rdata_o == trm_reg[7:0]) else $error("low count byte wrong");
  chk_term_high: assert property (drd && idx_reg == WDT_IDX_CNTH && !ctl_reg[7]
    |=> io_rdata_o == trm_reg[23:16]) else $error("high count byte wrong");
  chk_unmapped_zero: assert property (drd
    && (idx_reg < WDT_IDX_CTRL || idx_reg > WDT_IDX_MISC)
    |=> io_rdata_o == 8'h00) else $error("unmapped index not zero");
  chk_fire_enabled: assert property (out |-> $past(en, 2))
    else $error("timeout while disabled");
  cover property (nmi_o);
  cover property (sys_reset_o);
  cover property (irq_o[15]);
endmodule : wdt_asserts

bind wdt_top wdt_asserts i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .src_clk_i(src_clk_i), .io_addr_i(io_addr_i),
  .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .irq_o(irq_o), .nmi_o(nmi_o), .sys_reset_o(sys_reset_o));

// ### dv/wdt_host_model.sv
// host side of the index/data port pair
// assumes one-cycle strobes on sys_clk_i
`timescale 1ns/10ps
module wdt_host_model
  import wdt_pkg::*;
(
  input  wire logic        sys_clk_i,
  output logic      [15:0] io_addr_o,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [7:0]  io_wdata_o,
  input  wire logic [7:0]  io_rdata_i
);
  // ****************
  // access tasks
  // ****************
  initial begin
    io_addr_o  = 16'h0000;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_wdata_o = 8'h00;
  end
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
    @(posedge sys_clk_i);
    io_wr_o    <= 1'b1;
    io_addr_o  <= WDT_PORT_INDEX;
    io_wdata_o <= idx;
    @(posedge sys_clk_i);
    io_addr_o  <= WDT_PORT_DATA;
    io_wdata_o <= val;
    @(posedge sys_clk_i);
    io_wr_o    <= 1'b0;
    io_wdata_o <= ~val;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] val);
    @(posedge sys_clk_i);
    io_wr_o    <= 1'b1;
    io_addr_o  <= WDT_PORT_INDEX;
    io_wdata_o <= idx;
    @(posedge sys_clk_i);
    io_wr_o    <= 1'b0;
    io_rd_o    <= 1'b1;
    io_addr_o  <= WDT_PORT_DATA;
    @(posedge sys_clk_i);
    io_rd_o    <= 1'b0;
    @(posedge sys_clk_i);
    val = io_rdata_i;
  endtask : read_reg
endmodule : wdt_host_model

// ### dv/tb_wdt_top.sv
// self-checking bench for the watchdog block
// assumes the host model and the bound checker
`timescale 1ns/10ps
module tb_wdt_top
  import wdt_pkg::*;
;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        src_clk_i = 1'b0;
  logic [4:0]  sdiv      = 5'h00;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic [15:0] irq;
  logic        nmi;
  logic        srst;
  logic [17:0] seen;
  logic [17:0] expv;
  logic [7:0]  v;
  logic [7:0]  v2;
  int          fails      = 0;
  int          n_compared = 0;
  int          n_pulse    = 0;
  int          tbl[11]    = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
  logic [7:0]  idx_l[7]   = '{8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h40};

  wdt_host_model i_host (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata));
  wdt_top i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .src_clk_i(src_clk_i),
    .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .irq_o(irq), .nmi_o(nmi), .sys_reset_o(srst));

  // ****************
  // clocks and output monitor
  // ****************
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    sdiv      <= (sdiv == 5'd19) ? 5'd0 : sdiv + 5'd1;
    src_clk_i <= (sdiv < 5'd10);
    if (nmi || srst || irq != 16'h0000) begin
      n_pulse <= n_pulse + 1;
      seen    <= seen | {irq, nmi, srst};
    end
  end

  task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    i_host.write_reg(8'h40, 8'hff);
    foreach (idx_l[i]) begin
      i_host.read_reg(idx_l[i], v);
      check("reset_or_unmapped", 24'(v), 24'h0);
    end
    for (int i = 0; i < 3; i++) i_host.write_reg(WDT_IDX_CNTL + 8'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 3; i++) begin
      i_host.read_reg(WDT_IDX_CNTL + 8'(i), v);
      check("term_byte", 24'(v), 24'(8'h11 * (i + 1)));
    end
    i_host.write_reg(WDT_IDX_CNTH, 8'h00);
    i_host.write_reg(WDT_IDX_CNTM, 8'h00);
    i_host.write_reg(WDT_IDX_CNTL, 8'h05);
    for (int c = 0; c < 16; c++) begin
      i_host.write_reg(WDT_IDX_CTRL, 8'h00);
      i_host.write_reg(WDT_IDX_SEL, {4'(c), 4'h0});
      seen    = 18'h0;
      n_pulse = 0;
      expv    = 18'h0;
      if (c >= 1 && c <= 11) expv[tbl[c-1] + 2] = 1'b1;
      if (c == 12) expv = 18'h2;
      if (c == 13) expv = 18'h1;
      i_host.write_reg(WDT_IDX_CTRL, 8'h40);
      for (int k = 0; k < 400 && n_pulse == 0; k++) @(posedge sys_clk_i);
      if (n_pulse == 0 && expv != 18'h0) begin
        fails++;
        end_of_test();
      end
      repeat (200) @(posedge sys_clk_i);
      check("timeout_output", 24'(seen), 24'(expv));
      check("pulse_count", 24'(n_pulse), 24'(expv != 18'h0));
      i_host.read_reg(WDT_IDX_MISC, v);
      check("status", 24'(v), 24'h80);
    end
    i_host.write_reg(WDT_IDX_MISC, 8'h00);
    i_host.read_reg(WDT_IDX_MISC, v);
    check("status_read_only", 24'(v), 24'h80);
    i_host.write_reg(WDT_IDX_CTRL, 8'h00);
    i_host.write_reg(WDT_IDX_CNTM, 8'h0f);
    i_host.write_reg(WDT_IDX_CNTL, 8'hff);
    i_host.write_reg(WDT_IDX_CTRL, 8'h40);
    repeat (200) @(posedge sys_clk_i);
    i_host.write_reg(WDT_IDX_CTRL, 8'hc0);
    i_host.read_reg(WDT_IDX_CNTL, v);
    check("snap_range", 24'(v >= 8'd8 && v <= 8'd12), 24'h1);
    repeat (100) @(posedge sys_clk_i);
    i_host.read_reg(WDT_IDX_CNTL, v2);
    check("snap_held", 24'(v2), 24'(v));
    i_host.write_reg(WDT_IDX_CTRL, 8'h40);
    i_host.read_reg(WDT_IDX_CNTM, v2);
    check("term_mid", 24'(v2), 24'h0f);
    i_host.write_reg(WDT_IDX_CTRL, 8'hc0);
    i_host.read_reg(WDT_IDX_CNTL, v2);
    check("still_counting", 24'(v2 > v), 24'h1);
    for (int r = 0; r < 2; r++) begin
      i_host.write_reg(WDT_IDX_CTRL, 8'h00);
      i_host.write_reg(WDT_IDX_CTRL, 8'h80);
      i_host.read_reg(WDT_IDX_CNTL, v);
      check("cleared_and_stopped", 24'(v), 24'h0);
      repeat (100) @(posedge sys_clk_i);
    end
    end_of_test();
  end
endmodule : tb_wdt_top
